// [pcs_core_model.sv]
// Model: core interrupt entry and return pulses
`timescale 1ns/100ps
module pcs_core_model
    import pcs_pkg::*;
(
    input  wire logic clk,
    output logic      int_entry,
    output pcs_page_t int_page,
    output logic      int_return
);
    // ****************
    // Core events
    // ****************
    initial begin
        int_entry = 1'h0;
        int_page = 8'hA5;
        int_return = 1'h0;
    end
    // One-cycle entry pulse, page scrambled afterwards
    task automatic enter(input pcs_page_t p);
        @(posedge clk);
        int_entry <= 1'h1;
        int_page <= p;
        @(posedge clk);
        int_entry <= 1'h0;
        int_page <= ~p;
    endtask : enter
    // One-cycle return pulse
    task automatic leave;
        @(posedge clk);
        int_return <= 1'h1;
        @(posedge clk);
        int_return <= 1'h0;
    endtask : leave
endmodule : pcs_core_model

// [pcs_monitor.sv]
// Checker: port-level assertions for the page context stack
`timescale 1ns/100ps
module pcs_monitor
    import pcs_pkg::*;
(
    input wire logic        REF_CLK,
    input wire logic        SYS_RST,
    input wire logic        INT_ENTRY,
    input wire pcs_page_t   INT_PAGE,
    input wire logic        INT_RETURN,
    input wire pcs_page_t   ACTIVE_PAGE,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [3:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY
);
    // ****************
    // Event history
    // ****************
    logic ev1_r;
    logic ev2_r;
    logic bv1_r;
    logic wl_r;
    // Two-cycle delay line of core events
    always_ff @(posedge REF_CLK) begin
        ev1_r <= !SYS_RST && (INT_ENTRY || INT_RETURN);
        ev2_r <= !SYS_RST && ev1_r;
    end
    // Register write lands one edge after BVALID rises
    always_ff @(posedge REF_CLK) begin
        bv1_r <= !SYS_RST && S_AXI_BVALID;
        wl_r  <= !SYS_RST && S_AXI_BVALID && !bv1_r;       // Page may move next sample
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    sequence push_req;
        INT_ENTRY;
    endsequence
    // ****************
    // Assertions
    // ****************
    push_load_a: assert property (push_req |-> ##2 (ACTIVE_PAGE == $past(INT_PAGE, 2) ||
        ACTIVE_PAGE == $past(ACTIVE_PAGE, 2))) else $error("push page not loaded");
    idle_hold_a: assert property (!ev2_r && !wl_r |-> $stable(ACTIVE_PAGE))
        else $error("active page moved without cause");
    reset_zero_a: assert property ($fell(SYS_RST) |-> ACTIVE_PAGE == PCS_PAGE_RST)
        else $error("active page not zero after reset");
    read_active_a: assert property (S_AXI_ARREADY && S_AXI_ARADDR == PCS_OFF_ACTIVE |->
        S_AXI_RDATA[7:0] == ACTIVE_PAGE) else $error("active read differs from port");
    read_unmapped_a: assert property (S_AXI_ARREADY && S_AXI_ARADDR[1:0] != 2'h0 |->
        S_AXI_RRESP == PCS_RESP_SLVERR && S_AXI_RDATA == PCS_ZERO32) else $error("bad unmapped read");
    read_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    rvalid_drop_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read data kept after handshake");
endmodule : pcs_monitor

// [pcs_pkg.sv]
// Package: register map, reset values and state types of the page context stack
package pcs_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0] PCS_OFF_ACTIVE = 4'h0;
    localparam logic [3:0] PCS_OFF_SECOND = 4'h4;
    localparam logic [3:0] PCS_OFF_THIRD  = 4'h8;
    localparam logic [3:0] PCS_OFF_CTRL   = 4'hC;
    localparam int         PCS_ADDR_W     = 4;
    localparam int         PCS_PAGE_W     = 8;
    localparam int         PCS_DEPTH      = 3;
    localparam int         PCS_CTRL_EN_BIT = 0;

    // ****************************************************************
    // Reset values and responses
    // ****************************************************************
    localparam logic [7:0]  PCS_PAGE_RST    = 8'h00;
    localparam logic        PCS_EN_RST      = 1'b1;
    localparam logic [1:0]  PCS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PCS_RESP_SLVERR = 2'h2;
    localparam logic [31:0] PCS_ZERO32      = 32'h00000000;

    typedef logic [PCS_PAGE_W-1:0] pcs_page_t;

    // Slave channel states
    typedef enum logic [1:0] {
        PCS_IDLE = 2'b00,
        PCS_RESP = 2'b01
    } pcs_state_t;
endpackage : pcs_pkg

// [pcs_stack.sv]
// Module: three-entry page stack storage with push, pop and direct writes
`timescale 1ns/100ps
module pcs_stack
    import pcs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       push,
    input  wire logic       pop,
    input  wire pcs_page_t  push_page,
    input  wire logic [PCS_DEPTH-1:0] wr_en,
    input  wire pcs_page_t  wr_data,
    output pcs_page_t       entry [PCS_DEPTH]
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        pcs_page_t [PCS_DEPTH-1:0] ent;
    } pcs_stk_t;

    pcs_stk_t st_r;
    pcs_stk_t st_nxt;

    // Next entries: push and pop shift, direct writes overwrite one entry
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.ent[2] = st_r.ent[1];
            st_nxt.ent[1] = st_r.ent[0];
            st_nxt.ent[0] = push_page;
        end else if (pop) begin
            st_nxt.ent[0] = st_r.ent[1];
            st_nxt.ent[1] = st_r.ent[2];
        end else begin
            for (int i = 0; i < PCS_DEPTH; i++) begin
                if (wr_en[i]) begin
                    st_nxt.ent[i] = wr_data;
                end
            end
        end
    end

    // Register the stack
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= {PCS_DEPTH{PCS_PAGE_RST}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Expose entries
    genvar g;
    generate
        for (g = 0; g < PCS_DEPTH; g++) begin : g_out
            assign entry[g] = st_r.ent[g];
        end
    endgenerate
endmodule : pcs_stack

// [pcs_tb_top.sv]
// Testbench: register and stack scenarios for the page context stack
`timescale 1ns/100ps
module pcs_tb_top
    import pcs_pkg::*;
;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'h0;
    logic        wvalid = 1'h0;
    logic        bready = 1'h0;
    logic        arvalid = 1'h0;
    logic        rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, ent, ret;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    pcs_page_t   ipage, act;
    int          bad_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    localparam logic [1:0] OK = PCS_RESP_OKAY;
    initial forever #2.5 clk = ~clk;
    pcs_core_model core_u (.clk(clk), .int_entry(ent), .int_page(ipage), .int_return(ret));
    pcs_top dut_u (.REF_CLK(clk), .SYS_RST(rst), .INT_ENTRY(ent), .INT_PAGE(ipage),
        .INT_RETURN(ret), .ACTIVE_PAGE(act), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        chk({bresp, 32'h0}, {er, 32'h0});
        bready <= 1'h0;
    endtask : wr
    task automatic rdc(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!rvalid);
        chk({rresp, rdata}, {er, ed});
        arvalid <= 1'h0;
        rready <= 1'h0;
    endtask : rdc
    task automatic stk(input pcs_page_t a, input pcs_page_t s, input pcs_page_t t);
        rdc(PCS_OFF_ACTIVE, {24'h0, a}, OK);
        rdc(PCS_OFF_SECOND, {24'h0, s}, OK);
        rdc(PCS_OFF_THIRD, {24'h0, t}, OK);
        chk({26'h0, act}, {26'h0, a});
    endtask : stk
    task automatic give_verdict;
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        stk(8'h00, 8'h00, 8'h00);
        rdc(PCS_OFF_CTRL, 32'h1, OK);
        wr(PCS_OFF_ACTIVE, 32'hFFFFFF11, OK);
        wr(PCS_OFF_SECOND, 32'hABCDEF22, OK);
        wr(PCS_OFF_THIRD, 32'h00000133, OK);
        stk(8'h11, 8'h22, 8'h33);
        stk(8'h11, 8'h22, 8'h33);
        core_u.enter(8'h44);
        stk(8'h44, 8'h11, 8'h22);
        wr(PCS_OFF_SECOND, 32'h5A, OK);
        core_u.leave();
        stk(8'h5A, 8'h22, 8'h22);
        core_u.enter(8'h01);
        core_u.enter(8'h02);
        stk(8'h02, 8'h01, 8'h5A);
        core_u.leave();
        stk(8'h01, 8'h5A, 8'h5A);
        wr(PCS_OFF_CTRL, 32'h0, OK);
        core_u.enter(8'h77);
        core_u.leave();
        stk(8'h01, 8'h5A, 8'h5A);
        rdc(PCS_OFF_CTRL, 32'h0, OK);
        wr(PCS_OFF_CTRL, 32'h1, OK);
        wr(4'h2, 32'h55, PCS_RESP_SLVERR);
        wstrb <= 4'h0;
        wr(PCS_OFF_ACTIVE, 32'hEE, OK);
        wstrb <= 4'hF;
        rdc(4'h2, 32'h0, PCS_RESP_SLVERR);
        stk(8'h01, 8'h5A, 8'h5A);
        give_verdict();
    end
endmodule : pcs_tb_top
bind pcs_top pcs_monitor mon_u (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .INT_ENTRY(INT_ENTRY),
    .INT_PAGE(INT_PAGE), .INT_RETURN(INT_RETURN), .ACTIVE_PAGE(ACTIVE_PAGE),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// [pcs_top.sv]
// Module: page context stack with AXI4-Lite register access
//
// Notes on behaviour
// - Interrupt return loads the active page from the second entry.
// - All three entries are readable and writable by software.
// - Entries changed inside a handler decide the page restored on return.
// - Push only on interrupt entry, pop only on interrupt return.
// - Clearing the enable bit stops automatic switching, pushes and pops.
// - Software access to an entry never pushes or pops.
// - Second entry is eight bits wide and resets to zero.
`timescale 1ns/100ps
module pcs_top
    import pcs_pkg::*;
(
    input  wire logic                  REF_CLK,
    input  wire logic                  SYS_RST,
    input  wire logic                  INT_ENTRY,
    input  wire pcs_page_t             INT_PAGE,
    input  wire logic                  INT_RETURN,
    output pcs_page_t                  ACTIVE_PAGE,
    input  wire logic [PCS_ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output logic                       S_AXI_AWREADY,
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output logic                       S_AXI_WREADY,
    output logic [1:0]                 S_AXI_BRESP,
    output logic                       S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    input  wire logic [PCS_ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output logic                       S_AXI_ARREADY,
    output logic [31:0]                S_AXI_RDATA,
    output logic [1:0]                 S_AXI_RRESP,
    output logic                       S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY
);
    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic [PCS_DEPTH:0] pcs_dec(input logic [PCS_ADDR_W-1:0] a);
        pcs_dec = '0;
        case (a)
            PCS_OFF_ACTIVE: pcs_dec = 4'h1;
            PCS_OFF_SECOND: pcs_dec = 4'h2;
            PCS_OFF_THIRD:  pcs_dec = 4'h4;
            PCS_OFF_CTRL:   pcs_dec = 4'h8;
            default:        pcs_dec = 4'h0;
        endcase
    endfunction : pcs_dec

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        pcs_state_t              wst;
        logic                    aw_got;
        logic                    w_got;
        logic [PCS_ADDR_W-1:0]   awaddr;
        logic [31:0]             wdata;
        logic                    wstrb0;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        pcs_state_t              rst_s;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic                    auto_page_switch_enable;
        logic                    push;
        logic                    pop;
        pcs_page_t               push_page;
        logic [PCS_DEPTH-1:0]    wr_en;
        pcs_page_t               wr_data;
    } pcs_regs_t;

    pcs_regs_t s_r;
    pcs_regs_t s_nxt;
    pcs_page_t entry [PCS_DEPTH];
    logic [PCS_DEPTH:0] wsel;
    logic [PCS_DEPTH:0] rsel;

    assign wsel = pcs_dec(s_r.awaddr);
    assign rsel = pcs_dec(S_AXI_ARADDR);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.push = 1'b0;
        s_nxt.pop = 1'b0;
        s_nxt.wr_en = '0;
        s_nxt.push_page = INT_PAGE;
        // Core sequencing events, gated by the enable bit
        if (s_r.auto_page_switch_enable) begin
            s_nxt.push = INT_ENTRY;
            s_nxt.pop = INT_RETURN & ~INT_ENTRY;
        end
        // Write channel: take address and data in either order
        s_nxt.awready = 1'b0;
        s_nxt.wready = 1'b0;
        case (s_r.wst)
            PCS_IDLE: begin
                if (S_AXI_AWVALID && !s_r.aw_got && !s_r.awready) begin
                    s_nxt.awready = 1'b1;
                    s_nxt.aw_got = 1'b1;
                    s_nxt.awaddr = S_AXI_AWADDR;
                end
                if (S_AXI_WVALID && !s_r.w_got && !s_r.wready) begin
                    s_nxt.wready = 1'b1;
                    s_nxt.w_got = 1'b1;
                    s_nxt.wdata = S_AXI_WDATA;
                    s_nxt.wstrb0 = S_AXI_WSTRB[0];
                end
                if (s_r.aw_got && s_r.w_got) begin
                    s_nxt.aw_got = 1'b0;
                    s_nxt.w_got = 1'b0;
                    s_nxt.bvalid = 1'b1;
                    s_nxt.bresp = (wsel == '0) ? PCS_RESP_SLVERR : PCS_RESP_OKAY;
                    s_nxt.wst = PCS_RESP;
                    if (s_r.wstrb0) begin
                        // Plain stores, no stack movement
                        s_nxt.wr_en = wsel[PCS_DEPTH-1:0];
                        s_nxt.wr_data = s_r.wdata[PCS_PAGE_W-1:0];
                        if (wsel[PCS_DEPTH]) begin
                            s_nxt.auto_page_switch_enable = s_r.wdata[PCS_CTRL_EN_BIT];
                        end
                    end
                end
            end
            PCS_RESP: begin
                if (S_AXI_BREADY) begin
                    s_nxt.bvalid = 1'b0;
                    s_nxt.wst = PCS_IDLE;
                end
            end
            default: s_nxt.wst = PCS_IDLE;
        endcase
        // Read channel: read has no side effect on the stack
        s_nxt.arready = 1'b0;
        case (s_r.rst_s)
            PCS_IDLE: begin
                if (S_AXI_ARVALID && !s_r.arready) begin
                    s_nxt.arready = 1'b1;
                    s_nxt.rvalid = 1'b1;
                    s_nxt.rresp = (rsel == '0) ? PCS_RESP_SLVERR : PCS_RESP_OKAY;
                    s_nxt.rdata = PCS_ZERO32;
                    for (int i = 0; i < PCS_DEPTH; i++) begin
                        if (rsel[i]) begin
                            s_nxt.rdata[PCS_PAGE_W-1:0] = entry[i];
                        end
                    end
                    if (rsel[PCS_DEPTH]) begin
                        s_nxt.rdata[PCS_CTRL_EN_BIT] = s_r.auto_page_switch_enable;
                    end
                    s_nxt.rst_s = PCS_RESP;
                end
            end
            PCS_RESP: begin
                if (S_AXI_RREADY) begin
                    s_nxt.rvalid = 1'b0;
                    s_nxt.rst_s = PCS_IDLE;
                end
            end
            default: s_nxt.rst_s = PCS_IDLE;
        endcase
    end

    // Register all state
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            s_r <= '0;
            s_r.wst <= PCS_IDLE;
            s_r.rst_s <= PCS_IDLE;
            s_r.auto_page_switch_enable <= PCS_EN_RST;
            s_r.push_page <= PCS_PAGE_RST;
            s_r.wr_data <= PCS_PAGE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Stack storage
    // ****************************************************************
    pcs_stack u_stack (
        .clk       (REF_CLK),
        .rst       (SYS_RST),
        .push      (s_r.push),
        .pop       (s_r.pop),
        .push_page (s_r.push_page),
        .wr_en     (s_r.wr_en),
        .wr_data   (s_r.wr_data),
        .entry     (entry)
    );

    // Outputs straight from flip-flops
    assign ACTIVE_PAGE   = entry[0];
    assign S_AXI_AWREADY = s_r.awready;
    assign S_AXI_WREADY  = s_r.wready;
    assign S_AXI_BVALID  = s_r.bvalid;
    assign S_AXI_BRESP   = s_r.bresp;
    assign S_AXI_ARREADY = s_r.arready;
    assign S_AXI_RVALID  = s_r.rvalid;
    assign S_AXI_RDATA   = s_r.rdata;
    assign S_AXI_RRESP   = s_r.rresp;
endmodule : pcs_top
